// >>> core/cca_attr_bank.sv
/*
 * Controller capability attribute bank: byte read port over the
 * capability range and command limit enforcement.
 * Assumes capability straps are steady while rst is high.
 */
`timescale 1ns/1ns
module cca_attr_bank (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Capability straps, caught during reset, and lba_shift, which is not caught
    input wire logic cap_cache_present,
    input wire logic [15:0] cap_atomic_size_normal,
    input wire logic [15:0] cap_atomic_size_power_loss,
    input wire logic cap_vendor_cmd_layout_cfg,
    input wire logic cap_fused_op_support,
    input wire logic [15:0] cap_compare_write_atomic_size,
    input wire logic cap_sgl_basic,
    input wire logic cap_sgl_bit_bucket,
    input wire logic [3:0] lba_shift,
    // Byte read port
    input wire logic rd_req,
    input wire logic [cca_pkg::ADDR_W-1:0] rd_addr,
    output logic rd_valid_r,
    output logic [7:0] rd_data_r,
    // Command check port
    input wire logic cmd_valid,
    input wire cca_pkg::cca_cmd_e cmd_kind,
    input wire logic [15:0] cmd_nlb,
    output logic cmd_done_r,
    output logic [7:0] cmd_status_r,
    output logic cmd_atomic_r,
    output logic cmd_pf_atomic_r,
    // Status
    output logic atomic_rec_met_r
);
    import cca_pkg::*;

    logic cache_r;
    logic [15:0] norm_size_r;
    logic [15:0] pl_size_r;
    logic vcl_r;
    logic fused_r;
    logic [15:0] cw_size_r;
    logic sgl_r;
    logic bb_r;

    function automatic logic [7:0] pick16(input logic [15:0] v,
        input logic hi);
        pick16 = hi ? v[15:8] : v[7:0];
    endfunction

    // Field values as seen by the host
    wire [15:0] cw_size_eff = fused_r ? cw_size_r : 16'h0000;
    wire sgl_bb_eff = sgl_r & bb_r;
    wire [7:0] sgl_b0 = {7'h00, sgl_r};
    wire [7:0] sgl_b2 = {7'h00, sgl_bb_eff};

    // Byte decode; everything else in range reads zero
    wire sel_cache = rd_addr == OFS_CACHE;
    wire sel_awn = rd_addr == OFS_AWN_LO || rd_addr == OFS_AWN_HI;
    wire sel_apl = rd_addr == OFS_APL_LO || rd_addr == OFS_APL_HI;
    wire sel_vcl = rd_addr == OFS_VCL;
    wire sel_cwa = rd_addr == OFS_CWA_LO || rd_addr == OFS_CWA_HI;
    wire sel_sg0 = rd_addr == OFS_SGL_B0;
    wire sel_sg2 = rd_addr == OFS_SGL_B2;
    wire [7:0] rd_byte =
        sel_cache ? {7'h00, cache_r} :
        sel_awn ? pick16(norm_size_r, rd_addr[0]) :
        sel_apl ? pick16(pl_size_r, rd_addr[0]) :
        sel_vcl ? {7'h00, vcl_r} :
        sel_cwa ? pick16(cw_size_eff, rd_addr[0]) :
        sel_sg0 ? sgl_b0 :
        sel_sg2 ? sgl_b2 : 8'h00;

    // Recommended atomic size check
    wire [31:0] rec_blocks = ATOMIC_REC_BYTES >> lba_shift;
    wire [31:0] norm_blocks = {16'h0000, norm_size_r} + 32'h00000001;
    wire rec_met = norm_size_r == ATOMIC_ALL || norm_blocks >= rec_blocks;

    cca_chk_if ci ();
    assign ci.cmd_valid = cmd_valid;
    assign ci.cmd_kind = cmd_kind;
    assign ci.cmd_nlb = cmd_nlb;
    assign ci.cache = cache_r;
    assign ci.fused = fused_r;
    assign ci.cw_size = cw_size_eff;
    assign ci.norm_size = norm_size_r;
    assign ci.pl_size = pl_size_r;

    cca_cmd_check u_chk (
        .mclk(mclk),
        .rst(rst),
        .ci(ci)
    );

    // Straps caught while reset is held
    always_ff @(posedge mclk) begin
        if (rst) begin
            cache_r <= cap_cache_present;
            norm_size_r <= cap_atomic_size_normal;
            pl_size_r <= cap_atomic_size_power_loss;
            vcl_r <= cap_vendor_cmd_layout_cfg;
            fused_r <= cap_fused_op_support;
            cw_size_r <= cap_compare_write_atomic_size;
            sgl_r <= cap_sgl_basic;
            bb_r <= cap_sgl_bit_bucket;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rd_valid_r <= 1'b0;
            rd_data_r <= 8'h00;
            atomic_rec_met_r <= 1'b0;
        end else begin
            rd_valid_r <= rd_req;
            rd_data_r <= rd_req ? rd_byte : 8'h00;
            atomic_rec_met_r <= rec_met;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cmd_done_r <= 1'b0;
            cmd_status_r <= ST_SUCCESS;
            cmd_atomic_r <= 1'b0;
            cmd_pf_atomic_r <= 1'b0;
        end else begin
            cmd_done_r <= cmd_valid;
            cmd_status_r <= ci.res_status;
            cmd_atomic_r <= ci.res_atomic;
            cmd_pf_atomic_r <= ci.res_pf_atomic;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_cache;
        rd_req && rd_addr == OFS_CACHE |=> rd_valid_r &&
            rd_data_r == {7'h00, cache_r};
    endproperty
    a_cache: assert property (p_cache)
        else $error("cache byte wrong");

    property p_awn;
        rd_req && rd_addr == OFS_AWN_HI |=> rd_data_r == norm_size_r[15:8];
    endproperty
    a_awn: assert property (p_awn)
        else $error("normal atomic size high byte wrong");

    property p_all_atomic;
        cmd_valid && cmd_kind == CMD_WRITE && norm_size_r == ATOMIC_ALL &&
            ci.res_status == ST_SUCCESS |=> cmd_done_r && cmd_atomic_r;
    endproperty
    a_all_atomic: assert property (p_all_atomic)
        else $error("all-ones atomic size not honoured");

    property p_pf;
        cmd_valid && cmd_kind == CMD_WRITE && ci.res_status == ST_SUCCESS
            |=> cmd_pf_atomic_r == ($past(cmd_nlb) <= pl_size_r);
    endproperty
    a_pf: assert property (p_pf)
        else $error("power-fail atomic flag wrong");

    property p_apl;
        rd_req && rd_addr == OFS_APL_LO |=> rd_data_r == pl_size_r[7:0];
    endproperty
    a_apl: assert property (p_apl)
        else $error("power-fail atomic size low byte wrong");

    property p_sgl_basic;
        rd_req && rd_addr == OFS_SGL_B0 |=> rd_data_r == {7'h00, sgl_r};
    endproperty
    a_sgl_basic: assert property (p_sgl_basic)
        else $error("scatter-gather basic bit wrong");

    property p_vcl;
        rd_req && rd_addr == OFS_VCL |=> rd_data_r == {7'h00, vcl_r};
    endproperty
    a_vcl: assert property (p_vcl)
        else $error("vendor layout byte wrong");

    property p_cw_big;
        cmd_valid && cmd_kind == CMD_FUSED_CMP && cmd_nlb > cw_size_eff &&
            ci.res_status != ST_FUSED_MISSING
            |=> cmd_done_r && cmd_status_r == ST_INVALID_FIELD;
    endproperty
    a_cw_big: assert property (p_cw_big)
        else $error("oversized compare-and-write not failed");

    property p_cwa_zero;
        !fused_r && rd_req && rd_addr == OFS_CWA_LO |=> rd_data_r == 8'h00;
    endproperty
    a_cwa_zero: assert property (p_cwa_zero)
        else $error("compare-write size not zero without fused support");

    property p_bb;
        rd_req && rd_addr == OFS_SGL_B2 |=>
            rd_data_r == {7'h00, sgl_r & bb_r};
    endproperty
    a_bb: assert property (p_bb)
        else $error("bit bucket byte wrong");

    property p_sgl_zero;
        !sgl_r && rd_req && rd_addr >= OFS_SGL_B0 && rd_addr <= OFS_SGL_B3
            |=> rd_data_r == 8'h00;
    endproperty
    a_sgl_zero: assert property (p_sgl_zero)
        else $error("scatter-gather word not zero");

    property p_flush;
        cmd_valid && cmd_kind == CMD_FLUSH && cache_r &&
            ci.res_status != ST_FUSED_MISSING |=> cmd_status_r == ST_SUCCESS;
    endproperty
    a_flush: assert property (p_flush)
        else $error("flush refused with cache present");

    property p_resv;
        rd_req && (rd_addr == OFS_VCL + 12'h001 || rd_addr > OFS_SGL_B3)
            |=> rd_data_r == 8'h00;
    endproperty
    a_resv: assert property (p_resv)
        else $error("reserved byte not zero");

    c_read: cover property (rd_req ##1 rd_valid_r && rd_data_r != 8'h00);
    c_cw_fail: cover property (cmd_done_r &&
        cmd_status_r == ST_INVALID_FIELD);
    c_atomic: cover property (cmd_done_r && cmd_atomic_r &&
        !cmd_pf_atomic_r);
    c_pf: cover property (cmd_done_r && cmd_pf_atomic_r);
endmodule

// >>> core/cca_chk_if.sv
/*
 * Carrier between the attribute bank and its command checker.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
interface cca_chk_if;
    import cca_pkg::*;
    logic cmd_valid;
    cca_cmd_e cmd_kind;
    logic [15:0] cmd_nlb;
    logic cache;
    logic fused;
    logic [15:0] cw_size;
    logic [15:0] norm_size;
    logic [15:0] pl_size;
    logic [7:0] res_status;
    logic res_atomic;
    logic res_pf_atomic;
    modport bank (output cmd_valid, cmd_kind, cmd_nlb, cache, fused, cw_size,
        norm_size, pl_size, input res_status, res_atomic, res_pf_atomic);
    modport chk (input cmd_valid, cmd_kind, cmd_nlb, cache, fused, cw_size,
        norm_size, pl_size, output res_status, res_atomic, res_pf_atomic);
endinterface

// >>> core/cca_cmd_check.sv
/*
 * Command checker: judges each command against the reported limits
 * and tracks fused pair order.
 * Assumes at most one command per cycle, results read the same cycle.
 */
`timescale 1ns/1ns
module cca_cmd_check (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Bank side
    cca_chk_if.chk ci
);
    import cca_pkg::*;

    typedef enum logic {FS_IDLE, FS_WAIT_WR} cca_fstate_e;
    cca_fstate_e fs_r;
    cca_fstate_e fs_nxt;

    wire is_cache_cmd = ci.cmd_kind == CMD_FLUSH ||
        ci.cmd_kind == CMD_SETF_CACHE || ci.cmd_kind == CMD_GETF_CACHE;
    wire cw_too_big = ci.cmd_nlb > ci.cw_size;
    wire wr_atomic = ci.norm_size == ATOMIC_ALL || ci.cmd_nlb <= ci.norm_size;
    wire wr_pf_atomic = ci.cmd_nlb <= ci.pl_size;

    always_comb begin
        fs_nxt = fs_r;
        ci.res_status = ST_SUCCESS;
        ci.res_atomic = 1'b0;
        ci.res_pf_atomic = 1'b0;
        if (ci.cmd_valid) begin
            unique case (fs_r)
                FS_IDLE: begin
                    if (is_cache_cmd) begin
                        // Accepted only when a cache is reported
                        if (!ci.cache) begin
                            ci.res_status = ST_INVALID_FIELD;
                        end
                    end else if (ci.cmd_kind == CMD_FUSED_CMP) begin
                        // Oversized or unsupported pair fails
                        if (!ci.fused || cw_too_big) begin
                            ci.res_status = ST_INVALID_FIELD;
                        end else begin
                            fs_nxt = FS_WAIT_WR;
                        end
                    end else if (ci.cmd_kind == CMD_FUSED_WR) begin
                        // Write half without compare first
                        ci.res_status = ST_FUSED_ORDER;
                    end else if (ci.cmd_kind == CMD_WRITE) begin
                        ci.res_atomic = wr_atomic;
                        ci.res_pf_atomic = wr_pf_atomic;
                    end
                end
                FS_WAIT_WR: begin
                    fs_nxt = FS_IDLE;
                    if (ci.cmd_kind != CMD_FUSED_WR) begin
                        ci.res_status = ST_FUSED_MISSING;
                    end else if (cw_too_big) begin
                        ci.res_status = ST_INVALID_FIELD;
                    end else begin
                        ci.res_atomic = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            fs_r <= FS_IDLE;
        end else begin
            fs_r <= fs_nxt;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_order;
        ci.cmd_valid && ci.cmd_kind == CMD_FUSED_WR && fs_r == FS_IDLE
            |-> ci.res_status == ST_FUSED_ORDER;
    endproperty
    a_order: assert property (p_order)
        else $error("fused write without compare not refused");

    property p_pair;
        ci.cmd_valid && ci.cmd_kind == CMD_FUSED_CMP &&
            ci.res_status == ST_SUCCESS |=> fs_r == FS_WAIT_WR;
    endproperty
    a_pair: assert property (p_pair)
        else $error("accepted compare did not open a pair");

    c_pair: cover property (ci.cmd_valid && fs_r == FS_WAIT_WR &&
        ci.cmd_kind == CMD_FUSED_WR && ci.res_status == ST_SUCCESS);
endmodule

// >>> core/cca_pkg.sv
/*
 * Constants, command kinds and status codes of the controller
 * capability attribute bank.
 * Assumes byte addresses count from the start of the identify structure.
 */
// Function
// - Byte 525 bit 0 reports a volatile write cache; bits 7:1 read zero.
// - With a cache present, flush and cache feature commands are accepted.
// - Report zero-based normal atomic size; writes within it are atomic.
// - Normal atomic size all ones makes every write atomic.
// - Normal atomic size should reach 128KB scaled by block size.
// - Zero-based power-fail atomic size; writes within it survive power loss.
// - Byte 530 bit 0 reports standard vendor command layout; bits 7:1 zero.
// - Oversized compare-and-write fails with invalid field status.
// - Compare-write atomic size reads zero without fused pair support.
// - Scatter-gather bit 16 reports bit bucket support; reserved bits zero.
// - Scatter-gather bit 0 clear forces the whole word to zero.
// - Fused support bit 0; in a fused pair compare comes first.
package cca_pkg;
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_CACHE = 12'h20D;
    localparam logic [11:0] OFS_AWN_LO = 12'h20E;
    localparam logic [11:0] OFS_AWN_HI = 12'h20F;
    localparam logic [11:0] OFS_APL_LO = 12'h210;
    localparam logic [11:0] OFS_APL_HI = 12'h211;
    localparam logic [11:0] OFS_VCL = 12'h212;
    localparam logic [11:0] OFS_CWA_LO = 12'h214;
    localparam logic [11:0] OFS_CWA_HI = 12'h215;
    localparam logic [11:0] OFS_SGL_B0 = 12'h218;
    localparam logic [11:0] OFS_SGL_B2 = 12'h21A;
    localparam logic [11:0] OFS_SGL_B3 = 12'h21B;
    localparam logic [15:0] ATOMIC_ALL = 16'hFFFF;
    localparam logic [31:0] ATOMIC_REC_BYTES = 32'h00020000;
    localparam logic [7:0] ST_SUCCESS = 8'h00;
    localparam logic [7:0] ST_INVALID_FIELD = 8'h02;
    localparam logic [7:0] ST_FUSED_MISSING = 8'h0A;
    localparam logic [7:0] ST_FUSED_ORDER = 8'h0B;
    typedef enum logic [2:0] {
        CMD_READ,
        CMD_WRITE,
        CMD_FLUSH,
        CMD_SETF_CACHE,
        CMD_GETF_CACHE,
        CMD_FUSED_CMP,
        CMD_FUSED_WR,
        CMD_OTHER
    } cca_cmd_e;
endpackage

// >>> dv/cca_attr_bank_tb_top.sv
/*
 * Bench of the attribute bank: strap rows, byte map, command limits.
 * Assumes the host model drives the read and command ports.
 */
`timescale 1ns/1ns
module cca_attr_bank_tb_top;
    import cca_pkg::*;
    typedef struct packed {
        logic cache;
        logic [15:0] awn;
        logic [15:0] apl;
        logic vcl;
        logic fus;
        logic [15:0] cwa;
        logic sglb;
        logic bb;
        logic [3:0] sh;
        logic [15:0] e_cwa;
        logic e_bb;
        logic e_rec;
    } cca_row_s;
    logic mclk, rst, rd_req, rd_valid_r, cmd_valid, cmd_done_r;
    logic cmd_atomic_r, cmd_pf_atomic_r, atomic_rec_met_r;
    logic [11:0] rd_addr;
    logic [7:0] rd_data_r, cmd_status_r;
    logic [15:0] cmd_nlb;
    cca_cmd_e cmd_kind;
    cca_row_s r, rows [4];
    logic [15:0] wl [4];
    logic [15:0] big;
    logic [7:0] ec;
    int n_mismatch = 0;
    int checked = 0;
    cca_attr_bank dut (.mclk(mclk), .rst(rst),
        .cap_cache_present(r.cache), .cap_atomic_size_normal(r.awn),
        .cap_atomic_size_power_loss(r.apl),
        .cap_vendor_cmd_layout_cfg(r.vcl), .cap_fused_op_support(r.fus),
        .cap_compare_write_atomic_size(r.cwa), .cap_sgl_basic(r.sglb),
        .cap_sgl_bit_bucket(r.bb), .lba_shift(r.sh), .rd_req(rd_req),
        .rd_addr(rd_addr), .rd_valid_r(rd_valid_r), .rd_data_r(rd_data_r),
        .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_nlb(cmd_nlb),
        .cmd_done_r(cmd_done_r), .cmd_status_r(cmd_status_r),
        .cmd_atomic_r(cmd_atomic_r), .cmd_pf_atomic_r(cmd_pf_atomic_r),
        .atomic_rec_met_r(atomic_rec_met_r));
    cca_host_model h (.mclk(mclk), .rd_req(rd_req), .rd_addr(rd_addr),
        .rd_valid_r(rd_valid_r), .rd_data_r(rd_data_r),
        .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_nlb(cmd_nlb),
        .cmd_done_r(cmd_done_r), .cmd_status_r(cmd_status_r),
        .cmd_atomic_r(cmd_atomic_r), .cmd_pf_atomic_r(cmd_pf_atomic_r));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        if (n_mismatch == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic do_rst(input int n);
        rst = 1'b1;
        repeat (n) @(negedge mclk);
        rst = 1'b0;
    endtask
    task automatic rb(input logic [11:0] a, input logic [7:0] e);
        logic v;
        logic [7:0] d;
        h.rd(a, v, d);
        chk(v, 1'b1);
        chk(d, e);
    endtask
    task automatic cc(input cca_cmd_e k, input logic [15:0] n,
        input logic brk, input logic [7:0] est, input logic eat,
        input logic epf);
        logic [7:0] st;
        logic at, pf, dn;
        h.cmd(k, n, brk, st, at, pf, dn);
        chk(dn, 1'b1);
        chk(st, est);
        if (k == CMD_WRITE || k == CMD_FUSED_WR || est != 8'h00) begin
            chk(at, eat);
        end
        if (k == CMD_WRITE || est != 8'h00) begin
            chk(pf, epf);
        end
    endtask
    function automatic logic [7:0] exp_byte(input cca_row_s x,
        input logic [11:0] a);
        case (a)
            OFS_CACHE: return {7'h00, x.cache};
            OFS_AWN_LO: return x.awn[7:0];
            OFS_AWN_HI: return x.awn[15:8];
            OFS_APL_LO: return x.apl[7:0];
            OFS_APL_HI: return x.apl[15:8];
            OFS_VCL: return {7'h00, x.vcl};
            OFS_CWA_LO: return x.e_cwa[7:0];
            OFS_CWA_HI: return x.e_cwa[15:8];
            OFS_SGL_B0: return {7'h00, x.sglb};
            OFS_SGL_B2: return {7'h00, x.e_bb};
            default: return 8'h00;
        endcase
    endfunction
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        close_out();
    end
    initial begin
        rows[0] = {1'b1, 16'h001F, 16'h0007, 1'b1, 1'b1, 16'h0003, 1'b1,
            1'b1, 4'h9, 16'h0003, 1'b1, 1'b0};
        rows[1] = {1'b0, 16'hFFFF, 16'h0000, 1'b0, 1'b0, 16'h0005, 1'b0,
            1'b1, 4'hC, 16'h0000, 1'b0, 1'b1};
        rows[2] = {1'b1, 16'h00FF, 16'h00FF, 1'b0, 1'b1, 16'hFFFE, 1'b1,
            1'b0, 4'h9, 16'hFFFE, 1'b0, 1'b1};
        rows[3] = {1'b0, 16'h00FE, 16'h0010, 1'b1, 1'b0, 16'h0000, 1'b1,
            1'b1, 4'h9, 16'h0000, 1'b1, 1'b0};
        r = rows[1];
        do_rst(12);
        chk({rd_valid_r, cmd_done_r, cmd_status_r, atomic_rec_met_r},
            0);
        for (int i = 0; i < 4; i++) begin
            r = rows[i];
            do_rst(2);
            for (logic [11:0] a = 12'h20D; a <= 12'h21C; a++) begin
                rb(a, exp_byte(r, a));
            end
            rb(12'h7FF, 8'h00);
            chk(atomic_rec_met_r, r.e_rec);
            ec = r.cache ? ST_SUCCESS : ST_INVALID_FIELD;
            cc(CMD_FLUSH, 16'h0000, !r.cache, ec, 0, 0);
            cc(CMD_SETF_CACHE, 16'h0000, !r.cache, ec, 0, 0);
            cc(CMD_GETF_CACHE, 16'h0000, !r.cache, ec, 0, 0);
            big = r.cwa + 16'h0001;
            wl[0] = r.awn;
            wl[1] = r.awn + 16'h0001;
            wl[2] = r.apl;
            wl[3] = r.apl + 16'h0001;
            foreach (wl[j]) begin
                cc(CMD_WRITE, wl[j], 0, 8'h00, r.awn == ATOMIC_ALL ||
                    wl[j] <= r.awn, wl[j] <= r.apl);
            end
            if (r.fus) begin
                cc(CMD_FUSED_CMP, big, 0, 8'h02, 0, 0);
                cc(CMD_FUSED_CMP, r.cwa, 0, 8'h00, 0, 0);
                cc(CMD_FUSED_WR, r.cwa, 0, 8'h00, 1, 0);
                cc(CMD_FUSED_CMP, r.cwa, 0, 8'h00, 0, 0);
                cc(CMD_FUSED_WR, big, 0, 8'h02, 0, 0);
            end else begin
                cc(CMD_FUSED_CMP, 16'h0000, 0, 8'h02, 0, 0);
            end
        end
        r = rows[0];
        do_rst(2);
        r = rows[1];
        r.sh = rows[0].sh;
        rb(OFS_CACHE, 8'h01);
        rb(OFS_AWN_LO, 8'h1F);
        chk(atomic_rec_met_r, 1'b0);
        cc(CMD_FUSED_WR, 16'h0000, 0, 8'h0B, 0, 0);
        cc(CMD_FUSED_CMP, 16'h0000, 0, 8'h00, 0, 0);
        cc(CMD_READ, 16'h0000, 0, 8'h0A, 0, 0);
        cc(CMD_READ, 16'h0000, 0, 8'h00, 0, 0);
        cc(CMD_OTHER, 16'h0000, 0, 8'h00, 0, 0);
        do_rst(1);
        chk({rd_valid_r, cmd_done_r, cmd_status_r, cmd_atomic_r,
            cmd_pf_atomic_r, atomic_rec_met_r}, 0);
        rb(OFS_CACHE, 8'h00);
        close_out();
    end
endmodule

// >>> dv/cca_host_model.sv
/*
 * Host model: issues byte reads and commands toward the bank.
 * Assumes the bench clock; each answer comes one cycle after the request.
 */
`timescale 1ns/1ns
module cca_host_model (
    // Clock
    input wire logic mclk,
    // Read port
    output logic rd_req,
    output logic [cca_pkg::ADDR_W-1:0] rd_addr,
    input wire logic rd_valid_r,
    input wire logic [7:0] rd_data_r,
    // Command port
    output logic cmd_valid,
    output cca_pkg::cca_cmd_e cmd_kind,
    output logic [15:0] cmd_nlb,
    input wire logic cmd_done_r,
    input wire logic [7:0] cmd_status_r,
    input wire logic cmd_atomic_r,
    input wire logic cmd_pf_atomic_r
);
    import cca_pkg::*;
    logic cache_seen = 1'b0;
    initial begin
        rd_req = 1'b0;
        rd_addr = 12'h000;
        cmd_valid = 1'b0;
        cmd_kind = CMD_OTHER;
        cmd_nlb = 16'h0000;
    end
    // Released lines show the inverse of the last value, except cmd_kind, which holds it
    task automatic rd(input logic [11:0] a, output logic v,
        output logic [7:0] d);
        @(negedge mclk);
        rd_req = 1'b1;
        rd_addr = a;
        @(negedge mclk);
        rd_req = 1'b0;
        rd_addr = ~a;
        v = rd_valid_r;
        d = rd_data_r;
        if (a == OFS_CACHE) cache_seen = d[0];
    endtask
    task automatic cmd(input cca_cmd_e k, input logic [15:0] n,
        input logic brk, output logic [7:0] st, output logic at,
        output logic pf, output logic dn);
        st = 8'hFF;
        at = 1'b0;
        pf = 1'b0;
        dn = 1'b0;
        // Cache commands go out only once a cache was reported, or when brk is set
        if (!brk && !cache_seen && (k == CMD_FLUSH ||
            k == CMD_SETF_CACHE || k == CMD_GETF_CACHE)) return;
        @(negedge mclk);
        cmd_valid = 1'b1;
        cmd_kind = k;
        cmd_nlb = n;
        @(negedge mclk);
        cmd_valid = 1'b0;
        cmd_nlb = ~n;
        dn = cmd_done_r;
        st = cmd_status_r;
        at = cmd_atomic_r;
        pf = cmd_pf_atomic_r;
    endtask
endmodule
